// ==== logic/spf_consts.svh ====
// Constants for the seven-pin port with analog multiplexing
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH

// ==========================================
// Register offsets
`define SPF_OFF_PINS    3'h0
`define SPF_OFF_LATCH   3'h1
`define SPF_OFF_DIR     3'h2
`define SPF_OFF_AN_LO   3'h3
`define SPF_OFF_AN_HI   3'h4

// ==========================================
// Reset values
`define SPF_LAT_RST     7'h00
`define SPF_DIR_RST     7'h7f
`define SPF_AN_LO_RST   8'hff
`define SPF_AN_HI_RST   8'hff
`define SPF_ASEL_ALL    7'h7f

// ==========================================
// Analog channel of each pin
`define SPF_CH_P1       4'h6
`define SPF_CH_P2       4'h7
`define SPF_CH_P3       4'h8
`define SPF_CH_P4       4'h9
`define SPF_CH_P5       4'ha
`define SPF_CH_P6       4'hb
`define SPF_CH_P7       4'h5

// ==========================================
// Pins that a peripheral takes over or reads
`define SPF_PIN_CMP2    1
`define SPF_PIN_CMP1    2
`define SPF_PIN_CUR     3
`define SPF_PIN_REF     5
`define SPF_PIN_SS      7
`define SPF_PIN_DLY     1

// ==========================================
// Cleared values of the pin pipeline and read data
`define SPF_PIN_IDLE    7'h00
`define SPF_RD_IDLE     8'h00

`endif

// ==== logic/spf_pkg.sv ====
// Types shared by the seven-pin port
package spf_pkg;

  // ==========================================
  // Whole state of the port
  typedef struct packed {
    logic [7:1] lat;
    logic [7:1] dir;
    logic [7:0] an_lo;
    logic [7:0] an_hi;
    logic [7:1] meta;
    logic [7:1] sync;
    logic [7:0] rdata;
    logic [7:1] pout;
    logic [7:1] poe;
    logic [7:1] asel;
    logic       ss;
    logic       ctd;
  } spf_state_s;

endpackage : spf_pkg

// ==== logic/spf_port.sv ====
// Seven-pin bidirectional port with analog and peripheral overrides
`timescale 1ns/100ps
`include "spf_consts.svh"

module spf_port #(
  parameter int ADDR_W = 3
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [7:1]        pin_in,
  output logic      [7:1]        pin_out,
  output logic      [7:1]        pin_oe,
  input  wire logic              comparator_one_result_out,
  input  wire logic              comparator_two_result_out,
  input  wire logic              cmp_one_route_en,
  input  wire logic              cmp_two_route_en,
  input  wire logic              ref_voltage_out_en,
  input  wire logic              charge_timer_current_en,
  output logic                   serial_slave_select_in,
  output logic                   charge_timer_delay_in,
  output logic      [7:1]        analog_pin_sel
);

  // ==========================================
  // Parameter check
  if (ADDR_W < 3) begin : g_addr_w_check
    $error("ADDR_W too small for the register map");
  end

  // ==========================================
  // State
  localparam spf_pkg::spf_state_s ST_RST = '{
    lat:   `SPF_LAT_RST,
    dir:   `SPF_DIR_RST,
    an_lo: `SPF_AN_LO_RST,
    an_hi: `SPF_AN_HI_RST,
    meta:  `SPF_PIN_IDLE,
    sync:  `SPF_PIN_IDLE,
    rdata: `SPF_RD_IDLE,
    pout:  `SPF_PIN_IDLE,
    poe:   `SPF_PIN_IDLE,
    asel:  `SPF_ASEL_ALL,
    ss:    1'b0,
    ctd:   1'b0
  };

  spf_pkg::spf_state_s st_r;
  spf_pkg::spf_state_s st_nxt;

  logic [15:0] an_all;
  logic [7:1]  asel_now;
  logic [7:1]  dig_in;
  logic [7:1]  drv_en;
  logic [7:1]  drv_val;
  logic        sel_pins;
  logic        sel_lat;
  logic        sel_dir;
  logic        sel_lo;
  logic        sel_hi;

  assign sel_pins = (reg_addr == ADDR_W'(`SPF_OFF_PINS));
  assign sel_lat  = (reg_addr == ADDR_W'(`SPF_OFF_LATCH));
  assign sel_dir  = (reg_addr == ADDR_W'(`SPF_OFF_DIR));
  assign sel_lo   = (reg_addr == ADDR_W'(`SPF_OFF_AN_LO));
  assign sel_hi   = (reg_addr == ADDR_W'(`SPF_OFF_AN_HI));

  // ==========================================
  // Analog channel map
  always_comb begin
    an_all = {st_r.an_hi, st_r.an_lo};
    asel_now[1] = an_all[`SPF_CH_P1];
    asel_now[2] = an_all[`SPF_CH_P2];
    asel_now[3] = an_all[`SPF_CH_P3];
    asel_now[4] = an_all[`SPF_CH_P4];
    asel_now[5] = an_all[`SPF_CH_P5];
    asel_now[6] = an_all[`SPF_CH_P6];
    asel_now[7] = an_all[`SPF_CH_P7];
  end

  // ==========================================
  // Pin drive and digital input
  always_comb begin
    // Analog selection blocks the input buffer but not the driver
    dig_in = st_r.sync & ~asel_now;
    dig_in[`SPF_PIN_REF] = dig_in[`SPF_PIN_REF] & ~ref_voltage_out_en;
    drv_en = ~st_r.dir;
    drv_val = st_r.lat;
    if (cmp_two_route_en) begin
      drv_val[`SPF_PIN_CMP2] = comparator_two_result_out;
    end
    if (cmp_one_route_en) begin
      drv_val[`SPF_PIN_CMP1] = comparator_one_result_out;
    end
    // The reference turns off both driver and input of its pin; the charging source turns off only the driver of its pin
    if (charge_timer_current_en) begin
      drv_en[`SPF_PIN_CUR] = 1'b0;
    end
    if (ref_voltage_out_en) begin
      drv_en[`SPF_PIN_REF] = 1'b0;
    end
  end

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
    st_nxt.rdata = `SPF_RD_IDLE;
    st_nxt.asel = asel_now;
    st_nxt.pout = drv_val;
    st_nxt.poe = drv_en;
    st_nxt.ss = st_r.dir[`SPF_PIN_SS] & dig_in[`SPF_PIN_SS];
    st_nxt.ctd = st_r.dir[`SPF_PIN_DLY] & dig_in[`SPF_PIN_DLY];
    // Bit 0 of a latch or direction write is dropped; it has no pin
    if (reg_wr) begin
      if (sel_pins || sel_lat) begin
        st_nxt.lat = reg_wdata[7:1];
      end else if (sel_dir) begin
        st_nxt.dir = reg_wdata[7:1];
      end else if (sel_lo) begin
        st_nxt.an_lo = reg_wdata;
      end else if (sel_hi) begin
        st_nxt.an_hi = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (sel_pins) begin
        st_nxt.rdata = {dig_in, 1'b0};
      end else if (sel_lat) begin
        st_nxt.rdata = {st_r.lat, 1'b0};
      end else if (sel_dir) begin
        st_nxt.rdata = {st_r.dir, 1'b0};
      end else if (sel_lo) begin
        st_nxt.rdata = st_r.an_lo;
      end else if (sel_hi) begin
        st_nxt.rdata = st_r.an_hi;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata              = st_r.rdata;
  assign pin_out                = st_r.pout;
  assign pin_oe                 = st_r.poe;
  assign serial_slave_select_in = st_r.ss;
  assign charge_timer_delay_in  = st_r.ctd;
  assign analog_pin_sel         = st_r.asel;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_latch_drive: assert property (
    !st_r.dir[4] |=> pin_oe[4] && (pin_out[4] == $past(st_r.lat[4]))
  ) else $error("Pin 4 output does not follow its latch");

  chk_analog_read: assert property (
    reg_rd && sel_pins && an_all[`SPF_CH_P4] |=> !reg_rdata[4]
  ) else $error("Analog pin read back a digital level");

  chk_reset_state: assert property (disable iff (1'b0)
    !resetn |=> analog_pin_sel == `SPF_ASEL_ALL && st_r.dir == `SPF_DIR_RST
  ) else $error("Pins not analog inputs after reset");

  chk_reset_read: assert property (disable iff (1'b0)
    !resetn ##1 resetn && reg_rd && sel_pins |=> reg_rdata == 8'h00
  ) else $error("Digital read after reset not zero");

  chk_cmp2_over: assert property (
    cmp_two_route_en && !st_r.dir[1]
      |=> pin_oe[1] && (pin_out[1] == $past(comparator_two_result_out))
  ) else $error("Comparator two result missing on pin 1");

  chk_cmp1_over: assert property (
    cmp_one_route_en && !st_r.dir[2]
      |=> pin_oe[2] && (pin_out[2] == $past(comparator_one_result_out))
  ) else $error("Comparator one result missing on pin 2");

  chk_ref_pin_off: assert property (
    ref_voltage_out_en && reg_rd && sel_pins |=> !pin_oe[5] && !reg_rdata[5]
  ) else $error("Pin 5 digital path active under reference output");

  chk_bit0_zero: assert property (
    reg_rd && (sel_pins || sel_lat || sel_dir) |=> !reg_rdata[0]
  ) else $error("Bit 0 read back as one");

  chk_ss_feed: assert property (
    st_r.dir[7] && !asel_now[7] |=> serial_slave_select_in == $past(st_r.sync[7])
  ) else $error("Slave select does not follow pin 7");

  chk_delay_feed: assert property (
    !st_r.dir[1] |=> !charge_timer_delay_in
  ) else $error("Delay input active with pin 1 driven");

  chk_current_pin: assert property (
    charge_timer_current_en |=> !pin_oe[3]
  ) else $error("Pin 3 driven while charging current is on");

  chk_analog_channel_select_bit_back: assert property (
    reg_wr && sel_hi ##1 reg_rd && sel_hi |=> reg_rdata == $past(reg_wdata, 2)
  ) else $error("Upper analog select did not read back");

  chk_latch_path: assert property (
    reg_wr && sel_pins ##1 reg_rd && sel_lat
      |=> reg_rdata[7:1] == $past(reg_wdata[7:1], 2)
  ) else $error("Pin write did not reach the latch");

  // ==========================================
  // Bus checks

  chk_rdata_idle: assert property (
    !reg_rd
      |=> reg_rdata == 8'h00
  ) else $error("Read data present without a read");

  chk_unmapped_rd: assert property (
    reg_rd && (reg_addr > ADDR_W'(`SPF_OFF_AN_HI))
      |=> reg_rdata == 8'h00
  ) else $error("Unmapped index read back nonzero");

  chk_dir_readback: assert property (
    reg_rd && sel_dir
      |=> reg_rdata[7:1] == $past(st_r.dir)
  ) else $error("Direction read does not match register");

  chk_lat_read: assert property (
    reg_rd && sel_lat
      |=> reg_rdata[7:1] == $past(st_r.lat)
  ) else $error("Latch read does not return latch");

  chk_lo_write: assert property (
    reg_wr && sel_lo
      |=> st_r.an_lo == $past(reg_wdata)
  ) else $error("Lower analog select write lost");

  chk_hi_write: assert property (
    reg_wr && sel_hi
      |=> st_r.an_hi == $past(reg_wdata)
  ) else $error("Upper analog select write lost");

  chk_dir_write: assert property (
    reg_wr && sel_dir
      |=> st_r.dir == $past(reg_wdata[7:1])
  ) else $error("Direction write lost");

  chk_lat_only: assert property (
    reg_wr && sel_pins
      |=> st_r.lat == $past(reg_wdata[7:1])
  ) else $error("Pin register write did not load latch");

  chk_pins_no_dir: assert property (
    reg_wr && (sel_pins || sel_lat)
      |=> st_r.dir == $past(st_r.dir)
  ) else $error("Latch write disturbed direction");

  // ==========================================
  // Pin checks

  chk_pin_map: assert property (
    analog_pin_sel
      == $past({st_r.an_lo[5], st_r.an_hi[3:0], st_r.an_lo[7:6]})
  ) else $error("Analog pin select does not follow channel map");

  chk_pin1_read: assert property (
    reg_rd && sel_pins && !asel_now[1]
      |=> reg_rdata[1] == $past(st_r.sync[1])
  ) else $error("Pin 1 read does not show its level");

  chk_ss_analog: assert property (
    asel_now[7]
      |=> !serial_slave_select_in
  ) else $error("Slave select active on analog pin 7");

  chk_delay_analog: assert property (
    asel_now[1]
      |=> !charge_timer_delay_in
  ) else $error("Delay input active on analog pin 1");

  chk_ctd_feed: assert property (
    st_r.dir[1] && !asel_now[1]
      |=> charge_timer_delay_in == $past(st_r.sync[1])
  ) else $error("Delay input does not follow pin 1");

  chk_pin7_drive: assert property (
    !st_r.dir[7]
      |=> pin_oe[7] && (pin_out[7] == $past(st_r.lat[7]))
  ) else $error("Pin 7 output does not follow its latch");

  chk_cmp2_latch: assert property (
    !cmp_two_route_en && !st_r.dir[1]
      |=> pin_oe[1] && (pin_out[1] == $past(st_r.lat[1]))
  ) else $error("Pin 1 output does not follow its latch");

  chk_cmp1_latch: assert property (
    !cmp_one_route_en && !st_r.dir[2]
      |=> pin_oe[2] && (pin_out[2] == $past(st_r.lat[2]))
  ) else $error("Pin 2 output does not follow its latch");

  chk_cur_released: assert property (
    !charge_timer_current_en && !st_r.dir[3]
      |=> pin_oe[3]
  ) else $error("Pin 3 not driven with charging current off");

  chk_ref_drive: assert property (
    ref_voltage_out_en
      |=> !pin_oe[5]
  ) else $error("Pin 5 driven under reference output");

  cov_digital_out: cover property (
    reg_wr && sel_dir && reg_wdata == 8'h00 ##[1:20] pin_oe == 7'h7f
  );

  cov_cmp_route: cover property (
    cmp_two_route_en && !st_r.dir[1] ##1 pin_oe[1]
  );

  cov_pin_read: cover property (
    reg_rd && sel_pins ##1 reg_rdata != 8'h00
  );

  cov_ref_out: cover property (
    ref_voltage_out_en && !st_r.dir[5] ##1 !pin_oe[5]
  );

  cov_back_to_back: cover property (
    reg_wr && sel_pins ##1 reg_rd && sel_lat
  );

endmodule : spf_port

// ==== sim/spf_board.sv ====
// Board model facing the port pins
`timescale 1ns/100ps

// ====================
// Pin levels
module spf_board (
  input  wire logic       clk,
  input  wire logic [7:1] pin_out,
  input  wire logic [7:1] pin_oe,
  input  wire logic [7:1] drv_en,
  input  wire logic [7:1] drv_val,
  output logic      [7:1] pin_in
);
  logic [7:1] flt_r = 7'h55;

  // Released pins wander each cycle, so a stale level never passes for a read
  always @(posedge clk) begin
    flt_r <= ~flt_r;
  end

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((drv_en & drv_val) | (~drv_en & flt_r)));
endmodule : spf_board

// ==== sim/spf_port_tb_top.sv ====
// Testbench for the seven-pin port
`timescale 1ns/100ps
`include "spf_consts.svh"

module spf_port_tb_top;
  logic       clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, m8;
  logic [7:1] pin_in, pin_out, pin_oe, asel, drv_val = 7'h00, drv_en = 7'h7f, pv [2] = '{7'h5a, 7'h25};
  logic       c1 = 1'b0, c2 = 1'b0, rt1 = 1'b0, rt2 = 1'b0, cvr = 1'b0, cur = 1'b0, ss, ctd;
  logic [15:0] m;
  int         failures = 0, cmp_count = 0, cyc = 0, ch [1:7] = '{6, 7, 8, 9, 10, 11, 5};

  spf_port dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .comparator_one_result_out(c1), .comparator_two_result_out(c2), .cmp_one_route_en(rt1),
    .cmp_two_route_en(rt2), .ref_voltage_out_en(cvr), .charge_timer_current_en(cur),
    .serial_slave_select_in(ss), .charge_timer_delay_in(ctd), .analog_pin_sel(asel));
  spf_board board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en), .drv_val(drv_val),
    .pin_in(pin_in));

  initial begin
    forever #20 clk = ~clk;
  end

  // ====================
  // Bus and compare tasks
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr8

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rchk

  // Write, then read with no idle cycle between the two strobes
  task automatic wrchk(input logic [2:0] a, input logic [7:0] d, input logic [2:0] ra, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ra;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : wrchk

  task automatic wt();
    repeat (4) @(posedge clk);
    #1;
  endtask : wt

  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Run is about 150 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ====================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({1'b0, asel}, 8'h7f);
    chk({1'b0, pin_oe}, 8'h00);
    rchk(`SPF_OFF_PINS, 8'h00);
    rchk(`SPF_OFF_LATCH, 8'h00);
    rchk(`SPF_OFF_DIR, 8'hfe);
    rchk(`SPF_OFF_AN_LO, 8'hff);
    rchk(`SPF_OFF_AN_HI, 8'hff);
    rchk(3'h5, 8'h00);
    for (int k = 1; k < 8; k++) begin
      m = ~(16'h0001 << ch[k]);
      wr8(`SPF_OFF_AN_LO, m[7:0]);
      wr8(`SPF_OFF_AN_HI, m[15:8]);
      wt();
      chk({1'b0, asel}, {1'b0, ~(7'h01 << (k - 1))});
    end
    rchk(`SPF_OFF_AN_LO, 8'hdf);
    wr8(`SPF_OFF_AN_LO, 8'h1f);
    drv_en <= 7'h00;
    wrchk(`SPF_OFF_AN_HI, 8'hf0, `SPF_OFF_AN_HI, 8'hf0);
    wrchk(`SPF_OFF_PINS, 8'hab, `SPF_OFF_LATCH, 8'haa);
    wr8(`SPF_OFF_DIR, 8'h00);
    wt();
    chk({1'b0, pin_oe}, 8'h7f);
    chk({1'b0, pin_out}, 8'h55);
    wr8(`SPF_OFF_AN_LO, 8'hff);
    wr8(`SPF_OFF_AN_HI, 8'hff);
    wt();
    chk({1'b0, pin_out & pin_oe}, 8'h55);
    wr8(`SPF_OFF_AN_LO, 8'h1f);
    wr8(`SPF_OFF_AN_HI, 8'hf0);
    {rt1, rt2, cvr, cur, c1, c2} <= 6'b111110;
    wt();
    chk({6'h00, pin_out[2:1]}, 8'h02);
    chk({1'b0, pin_oe}, 8'h6b);
    @(posedge clk);
    {c1, c2} <= 2'b01;
    wt();
    chk({6'h00, pin_out[2:1]}, 8'h01);
    wr8(`SPF_OFF_DIR, 8'hff);
    {rt1, rt2, cur, drv_en} <= {3'b000, 7'h7f};
    rchk(`SPF_OFF_DIR, 8'hfe);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      drv_val <= pv[i];
      wt();
      m8 = {pv[i] & 7'h6f, 1'b0};
      rchk(`SPF_OFF_PINS, m8);
      chk({7'h00, ss}, {7'h00, pv[i][7]});
      chk({7'h00, ctd}, {7'h00, pv[i][1]});
    end
    // Mid-run reset; the first read is taken at the first edge out of reset
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    reg_addr <= `SPF_OFF_PINS;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h00);
    chk({1'b0, asel}, 8'h7f);
    rchk(`SPF_OFF_LATCH, 8'h00);
    wr8(`SPF_OFF_AN_LO, 8'hff);
    wr8(`SPF_OFF_AN_HI, 8'hff);
    wt();
    rchk(`SPF_OFF_PINS, 8'h00);
    tally_and_finish();
  end
endmodule : spf_port_tb_top
